// ### lfs_host_model.sv
// Host controller model: drives the enable/dimming pin and the sync pin.
// Assumes pins move only just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module lfs_host_model (
	// Clock
	input  wire logic i_core_clk,
	// Host pins
	output var  logic o_enable_dim,
	output var  logic o_freq_select_sync_pin
);
	initial begin
		o_enable_dim           = 1'b1;
		o_freq_select_sync_pin = 1'b1;
	end

	// Long low on enable is how a latched fault is cleared
	task automatic set_en(input logic v);
		@(negedge i_core_clk);
		o_enable_dim = v;
	endtask

	// Sync pin low is the fast way to stop the driver
	task automatic set_sync(input logic v);
		@(negedge i_core_clk);
		o_freq_select_sync_pin = v;
	endtask
endmodule
`default_nettype wire

// ### lfs_pkg.sv
// Package for the LED driver fault supervisor: timing counts, states, carriers.
// Assumes a 20 MHz oscillator-derived clock on every register.
package lfs_pkg;

	localparam int unsigned CLK_MHZ           = 20;
	// Undervoltage glitch filter: longest ignored glitch, rounded down
	localparam int unsigned UV_FILTER_US      = 50;
	localparam int unsigned UV_FILTER_CYC     = UV_FILTER_US * CLK_MHZ;
	// Enable-low shutdown time, in oscillator cycles
	localparam int unsigned EN_LOW_CYC        = 32750;
	// Partial-overcurrent timeout, in oscillator cycles
	localparam int unsigned POC_TIMEOUT_CYC   = 10000;
	// Sync-pin-low fast shutdown: least time, rounded up (ns)
	localparam int unsigned SYNC_LOW_NS       = 7000;
	localparam int unsigned CLK_PERIOD_NS     = 50;
	localparam int unsigned SYNC_LOW_CYC      =
		(SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Startup blanking of the partial-overcurrent check
	localparam int unsigned STARTUP_BLANK_CYC = 64;

	localparam int unsigned CNT_W = 16;

	typedef enum logic [1:0] {
		LFS_OFF   = 2'b00,
		LFS_START = 2'b01,
		LFS_RUN   = 2'b11,
		LFS_SHDN  = 2'b10
	} lfs_state_t;

	// Analog comparator results, asynchronous to the clock
	typedef struct packed {
		logic supply_above_rise;
		logic sense_above_rise;
		logic supply_below_fall;
		logic supply_below_shutdown;
		logic sw_cycle_limit;
		logic sw_secondary_limit;
		logic in_over_1x;
		logic in_over_2x;
		logic sw_secondary_ovp;
	} lfs_sense_t;

	// Power stage drive
	typedef struct packed {
		logic boost_en;
		logic gate_on;
		logic sinks_on;
	} lfs_drive_t;

endpackage

// ### lfs_supervisor.sv
// LED driver fault supervisor: undervoltage lockout, enable-low shutdown,
// latched and auto-restart faults, fault flag and power stage control.
// Assumes comparator levels and host pins asynchronous to i_core_clk.
//
// Notes on behaviour
// - Enable when supply and sense above rise
// - Disable after supply low over 50 us
// - Shut down below the 4.35 V level
// - Enable low 32750 cycles: shutdown, clear faults
// - In shutdown sinks off; wake on enable
// - Startup blanks some protection checks
// - Cycle limit: boost off only while the limit holds
// - Secondary switch limit latches all off
// - Twice input trip latches all off
// - One-to-two times trip: flag, keep running
// - Secondary overvoltage latches all off
// - Sync pin low over 7 us stops
// - Partial overcurrent ends within 10000 cycles
// - Undervoltage lockout clears latched faults
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor (
	// Clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_srst,
	// Host pins
	input  wire logic               i_enable_dim,
	input  wire logic               i_freq_select_sync_pin,
	// Analog comparators
	input  wire lfs_pkg::lfs_sense_t i_sense,
	// Power stage and flag
	output var  lfs_pkg::lfs_drive_t o_drive,
	output var  logic               o_fault_flag,
	output var  logic               o_low_power
);
	import lfs_pkg::*;

	//--------------------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------------------
	localparam int NS = 11;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] syn;
	assign raw_in = {i_enable_dim, i_freq_select_sync_pin, i_sense};

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sync
			lfs_sync3 #(.RST_VAL(g == NS - 2 ? 1'b1 : 1'b0)) u_sync (
				.i_core_clk (i_core_clk),
				.i_srst     (i_srst),
				.i_pin      (raw_in[g]),
				.o_level    (syn[g])
			);
		end
	endgenerate

	lfs_sense_t s;
	wire        en_pin   = syn[NS-1];
	wire        sync_pin = syn[NS-2];
	assign s = lfs_sense_t'(syn[NS-3:0]);

	//--------------------------------------------------------------
	// Undervoltage lockout
	//--------------------------------------------------------------
	logic             uv_ok;
	logic [CNT_W-1:0] uv_cnt;
	wire rise_ok   = s.supply_above_rise && s.sense_above_rise;
	wire uv_expire = (uv_cnt >= CNT_W'(UV_FILTER_CYC));
	wire uv_trip   = uv_ok && (s.supply_below_shutdown || uv_expire);
	wire next_uv_ok = uv_ok ? !uv_trip : rise_ok;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			uv_cnt <= '0;
			uv_ok  <= 1'b0;
		end else begin
			if (!s.supply_below_fall || !uv_ok) begin
				uv_cnt <= '0;
			end else if (!uv_expire) begin
				uv_cnt <= uv_cnt + CNT_W'(1);
			end
			uv_ok <= next_uv_ok;
		end
	end

	//--------------------------------------------------------------
	// Enable-low shutdown counter
	//--------------------------------------------------------------
	logic [CNT_W-1:0] en_cnt;
	wire en_done = (en_cnt >= CNT_W'(EN_LOW_CYC));

	always_ff @(posedge i_core_clk) begin
		if (i_srst || en_pin) begin
			en_cnt <= '0;
		end else if (!en_done) begin
			en_cnt <= en_cnt + CNT_W'(1);
		end
	end

	//--------------------------------------------------------------
	// Sync-pin-low fast stop
	//--------------------------------------------------------------
	logic [CNT_W-1:0] sy_cnt;
	wire sync_stop = (sy_cnt >= CNT_W'(SYNC_LOW_CYC));

	always_ff @(posedge i_core_clk) begin
		if (i_srst || sync_pin) begin
			sy_cnt <= '0;
		end else if (!sync_stop) begin
			sy_cnt <= sy_cnt + CNT_W'(1);
		end
	end

	//--------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------
	lfs_state_t       state;
	lfs_state_t       next_state;
	logic [CNT_W-1:0] st_cnt;
	wire blank_done = (st_cnt >= CNT_W'(STARTUP_BLANK_CYC));

	always_comb begin
		next_state = state;
		case (state)
			LFS_OFF:   if (uv_ok) next_state = LFS_START;
			LFS_START: if (blank_done) next_state = LFS_RUN;
			LFS_RUN:   if (en_done) next_state = LFS_SHDN;
			LFS_SHDN:  if (en_pin) next_state = LFS_START;
			default:   next_state = LFS_OFF;
		endcase
		if (state == LFS_START && en_done) begin
			next_state = LFS_SHDN;
		end
		if (!uv_ok) begin
			next_state = LFS_OFF;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state  <= LFS_OFF;
			st_cnt <= '0;
		end else begin
			state <= next_state;
			if (state != LFS_START) begin
				st_cnt <= '0;
			end else if (!blank_done) begin
				st_cnt <= st_cnt + CNT_W'(1);
			end
		end
	end

	//--------------------------------------------------------------
	// Fault latches and partial overcurrent
	//--------------------------------------------------------------
	logic             latched;
	logic             poc_active;
	logic [CNT_W-1:0] poc_cnt;
	wire active     = (state == LFS_START) || (state == LFS_RUN);
	wire clear_all  = !uv_ok || (state == LFS_SHDN);
	wire poc_expire = (poc_cnt >= CNT_W'(POC_TIMEOUT_CYC));
	wire hard_trip  = active &&
		(s.sw_secondary_limit || s.in_over_2x || s.sw_secondary_ovp ||
		 (poc_active && poc_expire));
	wire poc_check  = (state == LFS_RUN) && s.in_over_1x && !latched;

	always_ff @(posedge i_core_clk) begin
		if (i_srst || clear_all) begin
			latched    <= 1'b0;
			poc_active <= 1'b0;
			poc_cnt    <= '0;
		end else begin
			if (hard_trip) begin
				latched <= 1'b1;
			end
			poc_active <= poc_check && !poc_expire;
			if (!poc_check) begin
				poc_cnt <= '0;
			end else if (!poc_expire) begin
				poc_cnt <= poc_cnt + CNT_W'(1);
			end
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	wire run_ok    = active && !latched && !hard_trip && !sync_stop;
	lfs_drive_t next_drive;
	assign next_drive.gate_on  = run_ok;
	assign next_drive.sinks_on = run_ok && (state == LFS_RUN);
	assign next_drive.boost_en = run_ok && !s.sw_cycle_limit;
	wire next_flag = latched || hard_trip || poc_active;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_drive      <= '0;
			o_fault_flag <= 1'b0;
			o_low_power  <= 1'b0;
		end else begin
			o_drive      <= next_drive;
			o_fault_flag <= next_flag && !clear_all;
			o_low_power  <= (state == LFS_SHDN);
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	a_latch_all_off: assert property (latched |=> !o_drive.gate_on && !o_drive.sinks_on)
		else $error("latched fault left stage on");
	a_latch_holds: assert property (latched && uv_ok && state != LFS_SHDN |=> latched)
		else $error("latch dropped without clear");
	a_latch_flag: assert property (latched && !clear_all |=> o_fault_flag)
		else $error("flag low with latched fault");
	a_cycle_limit: assert property (
		run_ok && s.sw_cycle_limit && state == LFS_RUN |=> o_drive.gate_on && !o_drive.boost_en
		&& o_drive.sinks_on)
		else $error("cycle limit handled wrongly");
	a_uv_clear: assert property (!uv_ok |=> !latched && state == LFS_OFF)
		else $error("lockout did not clear");
	a_shdn_sinks: assert property (state == LFS_SHDN |=> !o_drive.sinks_on && o_low_power)
		else $error("sinks on in shutdown");
	a_en_restart: assert property (en_pin |=> en_cnt == 0)
		else $error("enable counter not restarted");
	a_en_shutdown: assert property (state == LFS_RUN && en_done && uv_ok |=> state == LFS_SHDN)
		else $error("no shutdown after enable low");
	a_poc_bound: assert property (poc_cnt <= CNT_W'(POC_TIMEOUT_CYC))
		else $error("partial overcurrent too long");
	a_sync_stop: assert property (sync_stop |=> !o_drive.gate_on && !o_drive.boost_en)
		else $error("sync low did not stop");
	a_uv_filter: assert property (uv_ok && !s.supply_below_shutdown && uv_cnt < 10 |=> uv_ok)
		else $error("lockout without filter");
	a_startup_blank: assert property (state == LFS_START |-> !poc_active)
		else $error("check active at startup");

	c_run:     cover property (state == LFS_START ##1 state == LFS_RUN);
	c_latch:   cover property (state == LFS_RUN ##1 latched);
	c_poc:     cover property (poc_active ##1 !poc_active && !latched);
	c_shdn:    cover property (state == LFS_SHDN ##1 state == LFS_START);
endmodule
`default_nettype wire

// ### lfs_sync3.sv
// Three-stage pin synchroniser; output changes when stages two and three agree.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lfs_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_srst,
	// Pin and result
	input  wire logic i_pin,
	output var  logic o_level
);
	logic s1;
	logic s2;
	logic s3;
	wire  agree = (s2 == s3);

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s1      <= RST_VAL;
			s2      <= RST_VAL;
			s3      <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
			if (agree) begin
				o_level <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench for the fault supervisor: power-up, trips, lockout, shutdown.
// Assumes the host model owns the enable and sync pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lfs_pkg::*;
	localparam logic [4:0] ON = 5'h1c;
	localparam logic [4:0] OFF = 5'h00;
	localparam logic [4:0] LATCH = 5'h02;
	localparam logic [4:0] LP = 5'h01;
	logic       i_core_clk;
	logic       i_srst;
	wire logic  i_enable_dim;
	wire logic  i_freq_select_sync_pin;
	lfs_sense_t i_sense;
	lfs_drive_t o_drive;
	logic       o_fault_flag;
	logic       o_low_power;
	wire logic [4:0] outs;
	int         n_errors;
	int         samples_checked;
	assign outs = {o_drive, o_fault_flag, o_low_power};

	lfs_host_model host (.i_core_clk(i_core_clk), .o_enable_dim(i_enable_dim),
		.o_freq_select_sync_pin(i_freq_select_sync_pin));
	lfs_supervisor dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
		.i_enable_dim(i_enable_dim), .i_freq_select_sync_pin(i_freq_select_sync_pin),
		.i_sense(i_sense), .o_drive(o_drive), .o_fault_flag(o_fault_flag),
		.o_low_power(o_low_power));

	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic stop_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [4:0] e, input logic [4:0] m, input string s);
		samples_checked++;
		if ((outs & m) !== (e & m)) begin
			n_errors++;
			$display("[ERR] %0t %s got %b exp %b", $time, s, outs, e);
		end
	endtask
	task automatic chk_n(input int g, input int e, input string s);
		samples_checked++;
		if (g != e) begin
			n_errors++;
			$display("[ERR] %0t %s got %0d exp %0d", $time, s, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task automatic wait_out(input logic [4:0] e, input int n, input string s);
		for (int k = 0; k < n && outs !== e; k++) @(negedge i_core_clk);
		chk(e, 5'h1f, s);
	endtask
	task automatic rail(input logic ok);
		i_sense.supply_above_rise = ok;
		i_sense.supply_below_fall = !ok;
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_power_up;
		i_sense.supply_above_rise = 1'b1;
		cyc(100);
		chk(OFF, 5'h1f, "enabled on supply alone");
		i_sense.sense_above_rise = 1'b1;
		wait_out(ON, 120, "power-up");
	endtask
	task automatic t_cycle_limit;
		int n;
		n = 0;
		i_sense.sw_cycle_limit = 1'b1;
		cyc(2);
		i_sense.sw_cycle_limit = 1'b0;
		for (int k = 0; k < 12; k++) begin
			cyc(1);
			chk(ON, 5'h0f, "cycle limit side effect");
			if (outs[4] !== 1'b1) n++;
		end
		chk_n(n, 2, "boost off cycles");
	endtask
	task automatic t_poc;
		i_sense.in_over_1x = 1'b1;
		wait_out(5'h1e, 20, "partial overcurrent");
		cyc(300);
		chk(5'h1e, 5'h1f, "partial overcurrent hold");
		i_sense.in_over_1x = 1'b0;
		wait_out(ON, 20, "partial overcurrent clear");
		i_sense.in_over_1x = 1'b1;
		cyc(9900);
		chk(5'h1e, 5'h1f, "partial overcurrent before timeout");
		wait_out(LATCH, 200, "partial overcurrent timeout");
		i_sense.in_over_1x = 1'b0;
		rail(1'b0);
		cyc(1100);
		chk(OFF, 5'h1f, "lockout clears timeout latch");
		rail(1'b1);
		wait_out(ON, 120, "restart after timeout");
	endtask
	task automatic t_latch(input int b);
		i_sense[b] = 1'b1;
		wait_out(LATCH, 10, "hard trip");
		i_sense[b] = 1'b0;
		host.set_en(1'b0);
		cyc(50);
		host.set_en(1'b1);
		cyc(50);
		chk(LATCH, 5'h1f, "latch after dimming");
		rail(1'b0);
		cyc(1100);
		chk(OFF, 5'h1f, "lockout clears latch");
		rail(1'b1);
		wait_out(ON, 120, "restart after lockout");
	endtask
	task automatic t_uv;
		rail(1'b0);
		cyc(900);
		rail(1'b1);
		cyc(20);
		chk(ON, 5'h1f, "glitch ignored");
		rail(1'b0);
		cyc(995);
		chk(ON, 5'h1f, "lockout too early");
		wait_out(OFF, 30, "lockout");
		rail(1'b1);
		wait_out(ON, 120, "restart");
		i_sense.supply_below_shutdown = 1'b1;
		wait_out(OFF, 15, "shutdown level");
		i_sense.supply_below_shutdown = 1'b0;
		wait_out(ON, 120, "restart");
	endtask
	task automatic t_sync;
		host.set_sync(1'b0);
		cyc(100);
		chk(ON, 5'h1f, "short sync low");
		for (int k = 0; k < 60 && outs[4:2] !== 3'b000; k++) cyc(1);
		chk(OFF, 5'h1c, "sync stop");
		host.set_sync(1'b1);
		wait_out(ON, 120, "sync restart");
	endtask
	task automatic t_long_low;
		i_sense.sw_secondary_ovp = 1'b1;
		wait_out(LATCH, 10, "overvoltage trip");
		i_sense.sw_secondary_ovp = 1'b0;
		host.set_en(1'b0);
		cyc(20000);
		host.set_en(1'b1);
		cyc(20);
		host.set_en(1'b0);
		cyc(32700);
		chk(LATCH, 5'h1f, "enable counter restart");
		wait_out(LP, 200, "low power");
		host.set_en(1'b1);
		wait_out(ON, 200, "wake on enable");
	endtask

	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	initial begin
		#4500000;
		n_errors++;
		stop_test();
	end
	initial begin
		n_errors = 0;
		samples_checked = 0;
		i_srst = 1'b1;
		i_sense = '0;
		cyc(12);
		i_srst = 1'b0;
		t_power_up();
		t_cycle_limit();
		t_poc();
		t_latch(3);
		t_latch(1);
		t_latch(0);
		t_uv();
		t_sync();
		t_long_low();
		stop_test();
	end
endmodule
`default_nettype wire
